// File: src/port_device_control_status.sv
// per-port device control and device status registers behind an apb slave
//
// Summary of operation
// - bits 0-3 error report enables, reset clears
// - relaxed ordering bit 4 reads zero
// - payload field 7:5, 0=128B, 1=256B
// - payload encodings 2-7 behave as 128 bytes
// - bit 8 picks tag range in debug
// - wide tag bit otherwise plain read/write
// - phantom function bit 9 reads zero
// - aux pm bit 10 sticky across hot and warm resets, and across cold resets while aux power is present
// - no snoop bit 11 reads zero
// - read request field 14:12 reads zero
// - status 0-3 latch errors, write-one clears
// - unsupported request sets status bit 3
// - status bit 4 shows aux power present
// - status bit 5 pending always zero
`timescale 1ns/100ps
`default_nettype none
`include "port_dev_defs.svh"

module port_device_control_status #(
  parameter int ADDR_W = 12                      // apb byte address width
) (
  // clock and aux power-on reset
  input  wire logic              clk_sys,        // 200 MHz core clock
  input  wire logic              nrst,           // aux power-on reset, active low
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // port resets and environment
  input  wire logic              hot_reset,      // level, clears non-sticky state
  input  wire logic              warm_reset,     // level, clears non-sticky state
  input  wire logic              cold_reset,     // level, clears non-sticky state
  input  wire logic              aux_power_present, // aux supply sensed
  input  wire logic              sequential_tag_debug, // debug tag sequencing on
  // error detection pulses from the transaction layer
  input  wire logic              correctable_err,
  input  wire logic              nonfatal_err,
  input  wire logic              fatal_err,
  input  wire logic              unsupported_req,
  // control outputs
  // every output below leaves straight from a flop
  output logic                   correctable_report_en,
  output logic                   nonfatal_report_en,
  output logic                   fatal_report_en,
  output logic                   unsupported_req_report_en,
  output logic      [8:0]        payload_limit,  // effective payload limit in bytes
  output logic      [7:0]        tag_limit,      // highest tag the generator may use
  output logic                   aux_power_pm_en,
  output logic                   irq             // level, unmasked event pending
);

  // ---------------------------------------------------------------- reset
  // rst_meta is read by rst_n alone, never by the rest of the logic
  logic rst_meta;                                // first synchroniser stage
  logic rst_n;                                   // synchronised reset

  // release nrst through two flops so every flop leaves reset on one edge
  // assertion stays asynchronous so the bank clears with no clock;
  // only the release is retimed, two cycles after nrst rises
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // any of the port resets clears the ordinary fields
  // they are synchronous levels and never touch the synchroniser
  // the sticky aux pm bit survives them while aux power holds
  logic port_reset;
  assign port_reset = hot_reset | warm_reset | cold_reset;

  // ---------------------------------------------------------------- decode
  // map a byte address to a register, shared by read and write paths
  // misaligned addresses match nothing and fall to sel_none, so they
  // are refused with pslverr instead of aliasing onto a register
  function automatic port_dev_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    port_dev_pkg::reg_sel_t sel;
    sel = port_dev_pkg::sel_none;
    // the four indices are distinct, so match order does not matter
    if (addr[1:0] == 2'h0) begin
      if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`DEV_CTL_IDX)) begin
        sel = port_dev_pkg::sel_ctl;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`DEV_STS_IDX)) begin
        sel = port_dev_pkg::sel_sts;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`IRQ_STS_IDX)) begin
        sel = port_dev_pkg::sel_irq_sts;
      end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(`IRQ_MASK_IDX)) begin
        sel = port_dev_pkg::sel_irq_mask;
      end
    end
    return sel;
  endfunction : decode

  port_dev_pkg::reg_sel_t sel;                   // register addressed now
  logic                   setup_phase;           // first cycle of a transfer
  logic                   wr_take;               // write commits this edge
  logic [15:0]            wr_mask;               // byte lanes enabled
  logic [15:0]            wr_data;               // write data in low half

  // only lanes 0 and 1 carry bits; no register here is wider than 16
  assign sel         = decode(paddr);
  // setup_phase marks the cycle that captures read data
  assign setup_phase = psel & ~penable;
  // pready is only high in the access cycle, so this is the commit edge
  // writes never commit in the setup cycle
  assign wr_take     = psel & penable & pready & pwrite;
  assign wr_mask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // a disabled lane reads as zeros here, but its fields are also
  // skipped by the pstrb tests below, so nothing is written from it
  assign wr_data     = pwdata[15:0] & wr_mask;

  // ---------------------------------------------------------------- error events
  logic [3:0] err_event;                         // error pulses in status order
  // pulses are one cycle wide; a held level sets the flag every cycle
  // index by class so bit order cannot drift from the status layout

  assign err_event[port_dev_pkg::err_correctable] = correctable_err;
  assign err_event[port_dev_pkg::err_nonfatal]    = nonfatal_err;
  assign err_event[port_dev_pkg::err_fatal]       = fatal_err;
  assign err_event[port_dev_pkg::err_unsupported] = unsupported_req;

  // ---------------------------------------------------------------- control
  // only writable fields are stored; hardwired zero fields cost no flops
  logic [3:0] report_en;                         // error report enables
  logic [2:0] payload_sel;                       // max_payload_sel as written
  logic       wide_tag_en;                       // wide_tag_en storage
  logic [3:0] next_report_en;
  logic [2:0] next_payload_sel;
  logic       next_wide_tag_en;
  logic       next_aux_power_pm_en;

  // next values of the control fields
  // a port reset outranks a write in the same cycle, so a write racing
  // a reset is lost and software must repeat it afterwards
  always_comb begin
    next_report_en       = report_en;
    next_payload_sel     = payload_sel;
    next_wide_tag_en     = wide_tag_en;
    next_aux_power_pm_en = aux_power_pm_en;
    // every field holds unless a reset or a committed write moves it
    if (port_reset) begin
      next_report_en   = 4'h0;
      next_payload_sel = 3'h0;
      next_wide_tag_en = 1'b0;
      // sticky across a cold reset only while aux power holds it; a cold start without it clears
      if (cold_reset && !aux_power_present) begin
        next_aux_power_pm_en = 1'b0;
      end
    end else if (wr_take && sel == port_dev_pkg::sel_ctl) begin
      // low lane holds enables and payload, high lane tag and aux bits
      // reserved payload codes are stored as written and read back
      if (pstrb[0]) begin
        next_report_en   = wr_data[`CTL_REPORT_LSB +: 4];
        next_payload_sel = wr_data[`CTL_PAYLOAD_MSB:`CTL_PAYLOAD_LSB];
      end
      if (pstrb[1]) begin
        next_wide_tag_en     = wr_data[`CTL_WIDE_TAG_BIT];
        next_aux_power_pm_en = wr_data[`CTL_AUX_PM_BIT];
      end
      // relaxed order, phantom, no snoop and read request bits are not stored
    end
  end

  // register the control fields
  // nrst is the aux power-on reset and clears the sticky bit as well
  // the other fields clear to zero, the same as after a port reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      report_en       <= 4'h0;
      payload_sel     <= 3'h0;
      wide_tag_en     <= 1'b0;
      aux_power_pm_en <= 1'b0;
    end else begin
      report_en       <= next_report_en;
      payload_sel     <= next_payload_sel;
      wide_tag_en     <= next_wide_tag_en;
      aux_power_pm_en <= next_aux_power_pm_en;
    end
  end

  // the enables only gate message generation outside this bank
  assign correctable_report_en     = report_en[0];
  assign nonfatal_report_en        = report_en[1];
  assign fatal_report_en           = report_en[2];
  assign unsupported_req_report_en = report_en[3];

  // ---------------------------------------------------------------- effective limits
  logic [8:0] next_payload_limit;
  logic [7:0] next_tag_limit;

  // decode the payload and tag limits; flopped so outputs are registered
  // the one-cycle lag is the price of flopped outputs; users must not
  // rely on a new limit in the cycle right after the write
  always_comb begin
    // reserved encodings fall to the smallest limit, safe for any receiver
    if (payload_sel == `PAYLOAD_ENC_256) begin
      next_payload_limit = `PAYLOAD_BYTES_256;
    end else begin
      next_payload_limit = `PAYLOAD_BYTES_128;
    end
    // outside debug the bit does nothing, so the narrow range stands
    // with debug on, the wide tag bit alone picks the range
    if (sequential_tag_debug && wide_tag_en) begin
      next_tag_limit = `TAG_MAX_WIDE;
    end else begin
      next_tag_limit = `TAG_MAX_NARROW;
    end
  end

  // register the limits
  // reset values equal the decode of an all-zero control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      payload_limit <= `PAYLOAD_BYTES_128;
      tag_limit     <= `TAG_MAX_NARROW;
    end else begin
      payload_limit <= next_payload_limit;
      tag_limit     <= next_tag_limit;
    end
  end

  // ---------------------------------------------------------------- status
  logic [3:0] err_detected;                      // sticky detection flags
  logic [3:0] next_err_detected;
  // interrupt registers sit outside the device status layout
  // both use one bit order: four error classes, then aux change
  logic [4:0] irq_status;                        // interrupt causes
  logic [4:0] irq_mask;                          // interrupt enables
  logic [4:0] next_irq_status;
  logic [4:0] next_irq_mask;
  logic       aux_seen;                          // aux power last cycle
  logic       aux_change;                        // aux power toggled

  // aux history resets low, so aux present at power-up raises one
  // change event after reset; software clears it with the rest
  assign aux_change = aux_power_present ^ aux_seen;

  // detection flags: set wins over a write-one clear in the same cycle
  // one generate slice per flag keeps the priority written once
  // a port reset still beats both set and clear
  for (genvar i = 0; i < 4; i++) begin : g_err
    logic clear;                                 // software write-one clear
    assign clear = wr_take && sel == port_dev_pkg::sel_sts && pstrb[0]
                   && wr_data[`STS_ERR_LSB + i];
    always_comb begin
      if (port_reset) begin
        next_err_detected[i] = 1'b0;
      end else begin
        // latched regardless of the matching report enable
        next_err_detected[i] = (err_detected[i] & ~clear) | err_event[i];
      end
    end
  end

  // interrupt status and mask, same layout: four errors then aux change
  // the aux change cause lives only here; device status shows the level
  // a port reset clears the mask too, so software re-arms afterwards
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    if (port_reset) begin
      next_irq_status = `IRQ_RESET;
      next_irq_mask   = `IRQ_RESET;
    end else begin
      if (wr_take && sel == port_dev_pkg::sel_irq_sts && pstrb[0]) begin
        next_irq_status = irq_status & ~wr_data[4:0];
      end
      // the mask takes the written field whole, no write-one semantics
      if (wr_take && sel == port_dev_pkg::sel_irq_mask && pstrb[0]) begin
        next_irq_mask = wr_data[4:0];
      end
      // events set after the clear so a coincident event is kept
      next_irq_status = next_irq_status | {aux_change, err_event};
    end
  end

  // register status, interrupt state and the aux power history
  // irq is flopped from the next values so it lines up with the status
  // flops instead of trailing them by a cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_detected <= 4'h0;
      irq_status   <= `IRQ_RESET;
      irq_mask     <= `IRQ_RESET;
      aux_seen     <= 1'b0;
      irq          <= 1'b0;
    end else begin
      err_detected <= next_err_detected;
      irq_status   <= next_irq_status;
      irq_mask     <= next_irq_mask;
      aux_seen     <= aux_power_present;
      irq          <= |(next_irq_status & next_irq_mask);
    end
  end

  // ---------------------------------------------------------------- read path
  logic [15:0] ctl_view;                         // device_control as read
  logic [15:0] sts_view;                         // device_status as read
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // assemble the register views; hardwired fields read zero
  // read-only fields are rebuilt here, never stored, so no write reaches them
  always_comb begin
    ctl_view = `CTL_RESET;
    ctl_view[`CTL_REPORT_LSB +: 4]                 = report_en;
    ctl_view[`CTL_RELAXED_BIT]                     = 1'b0;
    ctl_view[`CTL_PAYLOAD_MSB:`CTL_PAYLOAD_LSB]    = payload_sel;
    ctl_view[`CTL_WIDE_TAG_BIT]                    = wide_tag_en;
    ctl_view[`CTL_PHANTOM_BIT]                     = 1'b0;
    ctl_view[`CTL_AUX_PM_BIT]                      = aux_power_pm_en;
    ctl_view[`CTL_NO_SNOOP_BIT]                    = 1'b0;
    ctl_view[`CTL_READ_REQ_MSB:`CTL_READ_REQ_LSB]  = 3'h0;
    // status: sticky flags, live aux level, pending always low
    sts_view = `STS_RESET;
    sts_view[`STS_ERR_LSB +: 4]                    = err_detected;
    sts_view[`STS_AUX_BIT]                         = aux_power_present;
    sts_view[`STS_PENDING_BIT]                     = 1'b0;
  end

  // sample read data in the setup cycle, answer in the access cycle
  // a fixed one-cycle answer needs no wait states; an event between
  // setup and access shows only on the next read
  always_comb begin
    next_prdata  = prdata;
    next_pready  = setup_phase;                  // one access cycle, no wait states
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      // unmapped reads return zero with the error response
      unique case (sel)
        port_dev_pkg::sel_ctl:      next_prdata[15:0] = ctl_view;
        port_dev_pkg::sel_sts:      next_prdata[15:0] = sts_view;
        port_dev_pkg::sel_irq_sts:  next_prdata[4:0]  = irq_status;
        port_dev_pkg::sel_irq_mask: next_prdata[4:0]  = irq_mask;
        port_dev_pkg::sel_none:     next_pslverr      = 1'b1; // unmapped
      endcase
    end
  end

  // register the apb answer
  // pready and pslverr stand one cycle; prdata holds until next setup
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : port_device_control_status

`default_nettype wire

// File: src/port_dev_defs.svh
// offsets, field positions, reset values and limits of the port device control/status bank
`ifndef PORT_DEV_DEFS_SVH
`define PORT_DEV_DEFS_SVH

// register indices (word number), byte address is four times the index
`define DEV_CTL_IDX        10'h048
`define DEV_STS_IDX        10'h04a
`define IRQ_STS_IDX        10'h080
`define IRQ_MASK_IDX       10'h081

// control register field positions
`define CTL_REPORT_LSB     0
`define CTL_RELAXED_BIT    4
`define CTL_PAYLOAD_LSB    5
`define CTL_PAYLOAD_MSB    7
`define CTL_WIDE_TAG_BIT   8
`define CTL_PHANTOM_BIT    9
`define CTL_AUX_PM_BIT     10
`define CTL_NO_SNOOP_BIT   11
`define CTL_READ_REQ_LSB   12
`define CTL_READ_REQ_MSB   14

// status register field positions
`define STS_ERR_LSB        0
`define STS_AUX_BIT        4
`define STS_PENDING_BIT    5

// reset values
`define CTL_RESET          16'h0000
`define STS_RESET          16'h0000
`define IRQ_RESET          5'h00

// payload encodings and limits
`define PAYLOAD_ENC_256    3'h1
`define PAYLOAD_BYTES_128  9'h080
`define PAYLOAD_BYTES_256  9'h100

// tag range limits
`define TAG_MAX_NARROW     8'h1f
`define TAG_MAX_WIDE       8'hff

`endif

// File: src/port_dev_pkg.sv
// types shared by the port device control/status bank
package port_dev_pkg;

  // which register an apb address selects
  typedef enum logic [2:0] {
    sel_none,
    sel_ctl,
    sel_sts,
    sel_irq_sts,
    sel_irq_mask
  } reg_sel_t;

  // error event classes, in status bit order
  typedef enum logic [1:0] {
    err_correctable,
    err_nonfatal,
    err_fatal,
    err_unsupported
  } err_class_t;

endpackage : port_dev_pkg

// File: bench/port_dev_props.sv
// assertion checker for the port device control/status bank
`timescale 1ns/100ps
`default_nettype none
module port_dev_props #(
  parameter int ADDR_W = 12            // apb byte address width
) (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              hot_reset,
  input wire logic              warm_reset,
  input wire logic              cold_reset,
  input wire logic              sequential_tag_debug,
  input wire logic              correctable_report_en,
  input wire logic              nonfatal_report_en,
  input wire logic              fatal_report_en,
  input wire logic              unsupported_req_report_en,
  input wire logic [8:0]        payload_limit,
  input wire logic [7:0]        tag_limit,
  input wire logic              aux_power_pm_en,
  input wire logic              irq
);
  logic       any_rst;  // any port reset level
  logic       acc;      // completing access cycle
  logic       ctl_wr;   // committed control write with no port reset
  logic [3:0] rep;      // report enables as a vector
  assign any_rst = hot_reset | warm_reset | cold_reset;
  assign acc     = psel && penable && pready;
  assign ctl_wr  = acc && pwrite && paddr == ADDR_W'(12'h120) && !any_rst;
  assign rep = {unsupported_req_report_en, fatal_report_en, nonfatal_report_en,
                correctable_report_en};

  // one domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_report_clear: assert property (any_rst |=> rep == 4'h0)
    else $error("report enables not cleared by port reset");
  chk_report_write: assert property (ctl_wr && pstrb[0] |=> rep == $past(pwdata[3:0]))
    else $error("report enables do not follow control write");
  chk_payload_map: assert property (ctl_wr && pstrb[0] ##1 !any_rst |=>
    payload_limit == (($past(pwdata[7:5], 2) == 3'h1) ? 9'h100 : 9'h080))
    else $error("payload limit wrong for written encoding");
  chk_tag_narrow: assert property (!sequential_tag_debug |=> tag_limit == 8'h1f)
    else $error("tag range wide without debug setting");
  chk_tag_reset: assert property (any_rst |=> ##1 tag_limit == 8'h1f)
    else $error("tag range wide after port reset");
  chk_aux_sticky: assert property ((hot_reset || warm_reset) && aux_power_pm_en
    |=> aux_power_pm_en)
    else $error("aux pm enable lost on hot or warm reset");
  chk_aux_write: assert property (ctl_wr && pstrb[1] |=> aux_power_pm_en == $past(pwdata[10]))
    else $error("aux pm enable does not follow write");
  chk_ctl_ro: assert property (acc && !pwrite && paddr == ADDR_W'(12'h120)
    |-> (prdata & 32'hffff_fa10) == 32'h0)
    else $error("read-only control bits not zero");
  chk_sts_ro: assert property (acc && !pwrite && paddr == ADDR_W'(12'h128)
    |-> (prdata & 32'hffff_ffe0) == 32'h0)
    else $error("pending or reserved status bits not zero");
  chk_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("misaligned access not refused");
  chk_irq_hold: assert property (irq && !any_rst && !(psel && penable && pwrite) |=> irq)
    else $error("interrupt dropped without a clear");
endmodule : port_dev_props

bind port_device_control_status port_dev_props #(.ADDR_W(ADDR_W)) port_dev_props_i (
  .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .hot_reset(hot_reset), .warm_reset(warm_reset),
  .cold_reset(cold_reset), .sequential_tag_debug(sequential_tag_debug),
  .correctable_report_en(correctable_report_en), .nonfatal_report_en(nonfatal_report_en),
  .fatal_report_en(fatal_report_en), .unsupported_req_report_en(unsupported_req_report_en),
  .payload_limit(payload_limit), .tag_limit(tag_limit),
  .aux_power_pm_en(aux_power_pm_en), .irq(irq));
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the port device control/status bank
`timescale 1ns/100ps
`default_nettype none
`include "port_dev_defs.svh"
module tb;
  localparam logic [11:0] A_CTL = 12'(`DEV_CTL_IDX * 4);  // device_control
  localparam logic [11:0] A_STS = 12'(`DEV_STS_IDX * 4);  // device_status
  localparam logic [11:0] A_IST = 12'(`IRQ_STS_IDX * 4);  // irq status
  localparam logic [11:0] A_IMK = 12'(`IRQ_MASK_IDX * 4); // irq mask
  localparam logic [31:0] CTL_RW = 32'h0000_05ef;         // writable control bits
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  prst = 3'h0;      // hot, warm, cold
  logic        aux = 1'b0, dbg = 1'b0;
  logic [3:0]  err_pulse = 4'h0; // correctable, nonfatal, fatal, unsupported
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, aux_pm, irq;
  wire logic [3:0]  rep_en;
  wire logic [8:0]  payload_limit;
  wire logic [7:0]  tag_limit;
  int n_errors = 0;
  int num_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  port_device_control_status #(.ADDR_W(12)) port_device_control_status_i (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hot_reset(prst[0]), .warm_reset(prst[1]), .cold_reset(prst[2]),
    .aux_power_present(aux), .sequential_tag_debug(dbg),
    .correctable_err(err_pulse[0]), .nonfatal_err(err_pulse[1]),
    .fatal_err(err_pulse[2]), .unsupported_req(err_pulse[3]),
    .correctable_report_en(rep_en[0]), .nonfatal_report_en(rep_en[1]),
    .fatal_report_en(rep_en[2]), .unsupported_req_report_en(rep_en[3]),
    .payload_limit(payload_limit), .tag_limit(tag_limit),
    .aux_power_pm_en(aux_pm), .irq(irq));

  // single compare used for every result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick

  // one apb transfer; an edge always passes before setup so psel never toggles twice
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin n_errors++; $display("ERROR pready expected 1 seen timeout"); close_out(); end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q);
  endtask : rdchk

  // reset values of both registers and the derived limits
  task automatic s_reset;
    rdchk("ctl reset", A_CTL, 32'h0);
    rdchk("sts reset", A_STS, 32'h0);
    chk("payload reset", 32'h80, 32'(payload_limit));
    chk("tag reset", 32'h1f, 32'(tag_limit));
  endtask : s_reset

  // read-only bits, every payload encoding and every tag combination
  task automatic s_ctl;
    wr(A_CTL, 32'hffff_ffff);
    rdchk("ctl ro", A_CTL, CTL_RW);
    chk("report en", 32'hf, 32'(rep_en));
    chk("aux pm", 32'h1, 32'(aux_pm));
    for (int i = 0; i < 8; i++) begin
      wr(A_CTL, 32'(i) << 5);
      tick(2);
      chk("payload", (i == 1) ? 32'(`PAYLOAD_BYTES_256) : 32'(`PAYLOAD_BYTES_128),
          32'(payload_limit));
    end
    for (int i = 0; i < 4; i++) begin
      dbg <= i[1];
      wr(A_CTL, 32'(i[0]) << 8);
      tick(2);
      chk("tag", (i == 3) ? 32'hff : 32'h1f, 32'(tag_limit));
    end
  endtask : s_ctl

  // each error latches with reporting off, then write-zero and write-one
  task automatic s_status;
    wr(A_IMK, 32'h1f);
    wr(A_CTL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) err_pulse <= 4'h1 << i;
      @(posedge clk_sys) err_pulse <= 4'h0;
      tick(2);
      chk("irq set", 32'h1, 32'(irq));
      rdchk("sts err", A_STS, 32'h1 << i);
      wr(A_STS, 32'h0);
      rdchk("sts keep", A_STS, 32'h1 << i);
      wr(A_STS, 32'h1 << i);
      rdchk("sts clear", A_STS, 32'h0);
      wr(A_IST, 32'h1f);
      tick(2);
      chk("irq clear", 32'h0, 32'(irq));
    end
    wr(A_IMK, 32'h0);
    @(posedge clk_sys) err_pulse <= 4'hf;
    @(posedge clk_sys) err_pulse <= 4'h0;
    tick(2);
    chk("irq masked", 32'h0, 32'(irq));
    rdchk("sts all", A_STS, 32'hf);
    wr(A_STS, 32'hf);
    wr(A_IST, 32'h1f);
  endtask : s_status

  // aux power flag, sticky aux pm bit across port resets, refused address
  task automatic s_aux;
    logic [31:0] q; logic e;
    aux <= 1'b1;
    tick(2);
    rdchk("sts aux", A_STS, 32'h10);
    rdchk("irq aux", A_IST, 32'h10);
    for (int r = 0; r < 3; r++) begin
      wr(A_CTL, 32'h0000_040f);
      @(posedge clk_sys) prst <= 3'h1 << r;
      @(posedge clk_sys) prst <= 3'h0;
      tick(1);
      chk("aux sticky", 32'h1, 32'(aux_pm));
      chk("report cleared", 32'h0, 32'(rep_en));
    end
    aux <= 1'b0;
    wr(A_CTL, 32'h0000_0400);
    @(posedge clk_sys) prst <= 3'h4;
    @(posedge clk_sys) prst <= 3'h0;
    tick(1);
    chk("aux cold off", 32'h0, 32'(aux_pm));
    apb(1'b0, 12'h302, 32'h0, q, e);
    chk("bad addr err", 32'h1, 32'(e));
    chk("bad addr data", 32'h0, q);
    @(posedge clk_sys) nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(3);
    chk("aux pm nrst", 32'h0, 32'(aux_pm));
  endtask : s_aux

  initial begin
    tick(3);
    nrst <= 1'b1;
    tick(3);
    s_reset();
    s_ctl();
    s_status();
    s_aux();
    close_out();
  end
endmodule : tb
`default_nettype wire
